// file: hw/swpc_cfg.svh
// Constants of the system pin control block
`ifndef SWPC_CFG_SVH
`define SWPC_CFG_SVH

// ==========================================
// Timing
`define SWPC_CLK_PERIOD_NS 4
`define SWPC_RST_SEQ_NS    1000

// ==========================================
// Reset values
`define SWPC_HALT_RST      1'h0
`define SWPC_SCLK_RST      1'h0
`define SWPC_MODE_RST      3'h0
`define SWPC_SYNC_RST      1'h0

// ==========================================
// Switch mode encodings
`define SWPC_MODE_NORMAL   3'h0
`define SWPC_MODE_EEPROM   3'h1

// ==========================================
// Alternate pin positions: pin 2, pin 7, pin 9
`define SWPC_GP_IRQ0       0
`define SWPC_GP_EVENT      1
`define SWPC_GP_PORT3      2

// ==========================================
// Test access port
`define SWPC_IR_W          4
`define SWPC_IR_IDCODE     4'h1
`define SWPC_IR_BYPASS     4'hF
`define SWPC_IR_CAPTURE    4'h1

`endif

// file: hw/swpc_pin_ctrl.sv
// System pin control: reset sequencing, boot straps and alternate pins
`timescale 1ns/1ps
`default_nettype none
`include "swpc_cfg.svh"

module swpc_pin_ctrl
    import swpc_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Reset and strap pins
    input  wire logic       fundamental_reset_n,
    input  wire logic       reset_hold_strap,
    input  wire logic [2:0] switch_mode_strap,
    input  wire logic       common_clock_down_strap,
    input  wire logic       common_clock_up_strap,
    input  wire logic       aux_power_off_n,
    // Reset sequencing results
    output logic            pcie_fund_reset,
    output logic            core_logic_reset,
    output logic            smbus_master_en,
    output logic [2:0]      switch_mode,
    output logic            eeprom_init_req,
    output logic            mode_reserved,
    // Halt bit of the switch control register
    input  wire logic       halt_bit_clear,
    output logic            halt_bit,
    // Slot clock bits of the link status registers
    input  wire logic [1:0] down_sclk_we,
    input  wire logic [1:0] down_sclk_wdata,
    input  wire logic       up_sclk_we,
    input  wire logic       up_sclk_wdata,
    output logic [1:0]      down_slot_clock,
    output logic            up_slot_clock,
    // Auxiliary power
    input  wire logic       aux_power_req,
    output logic            aux_power_use,
    // Wake pin and its control
    input  wire logic       wake_direction_bit,
    input  wire logic       wake_assert_req,
    input  wire logic       wake_line_n_i,
    output logic            wake_line_n_o,
    output logic            wake_line_n_oe,
    output logic            wake_event,
    // General purpose pins 2, 7 and 9
    input  wire logic [2:0] gpio_alt_en,
    input  wire logic [2:0] gpio_sw_out,
    input  wire logic [2:0] gpio_sw_oe,
    input  wire logic [2:0] gpio_pin_i,
    output logic      [2:0] gpio_pin_o,
    output logic      [2:0] gpio_pin_oe,
    output logic      [2:0] gpio_sw_in,
    input  wire logic       general_purpose_event,
    input  wire logic       port3_reset_req,
    output logic            expander_irq0_n,
    // Test pins
    input  wire logic       jtag_tck,
    input  wire logic       jtag_trst_n,
    input  wire logic       jtag_tms,
    input  wire logic       jtag_tdi,
    output logic            jtag_tdo,
    output logic            jtag_tdo_oe
);

    localparam logic [9:0] SEQ_LAST = 10'((`SWPC_RST_SEQ_NS + `SWPC_CLK_PERIOD_NS - 1)
                                          / `SWPC_CLK_PERIOD_NS - 1);

    // ==========================================
    // Pin synchronisers
    logic [11:0] pins_s;
    logic        perst_n_s;
    logic        hold_s;
    logic [2:0]  mode_s;
    logic        cclk_dn_s;
    logic        cclk_up_s;
    logic        aux_off_n_s;
    logic        wake_n_s;
    logic [2:0]  gpio_s;

    swpc_sync #(.W (12)) u_sync (
        .clk (core_clk),
        .rst (rst),
        .d   ({gpio_pin_i, !wake_line_n_i, aux_power_off_n,
               common_clock_up_strap, common_clock_down_strap,
               switch_mode_strap, reset_hold_strap, fundamental_reset_n}),
        .q   (pins_s)
    );

    assign perst_n_s   = pins_s[0];
    assign hold_s      = pins_s[1];
    assign mode_s      = pins_s[4:2];
    assign cclk_dn_s   = pins_s[5];
    assign cclk_up_s   = pins_s[6];
    assign aux_off_n_s = pins_s[7];
    assign wake_n_s    = !pins_s[8]; // Synced inverted so reset reads the idle level
    assign gpio_s      = pins_s[11:9];

    // ==========================================
    // Release detect on fundamental reset
    logic perst_n_d_r;
    logic release_p;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            perst_n_d_r <= 1'h0;
        end else begin
            perst_n_d_r <= perst_n_s;
        end
    end

    assign release_p = perst_n_s && !perst_n_d_r;

    // ==========================================
    // Reset sequencer
    swpc_state_e state_r;
    swpc_state_e state_nxt;
    logic [9:0]  seq_cnt_r;
    logic        hold_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_FUND: begin
                if (release_p) begin
                    state_nxt = ST_SEQ;
                end
            end
            ST_SEQ: begin
                if (!perst_n_s) begin
                    state_nxt = ST_FUND;
                end else if (seq_cnt_r == SEQ_LAST) begin
                    state_nxt = hold_r ? ST_HALT : ST_RUN;
                end
            end
            ST_HALT: begin
                if (!perst_n_s) begin
                    state_nxt = ST_FUND;
                end else if (!halt_bit) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!perst_n_s) begin
                    state_nxt = ST_FUND;
                end
            end
            default: state_nxt = ST_FUND;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_FUND;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seq_cnt_r <= 10'h000;
        end else if (state_r == ST_SEQ) begin
            seq_cnt_r <= seq_cnt_r + 10'h001;
        end else begin
            seq_cnt_r <= 10'h000;
        end
    end

    assign pcie_fund_reset  = (state_r == ST_FUND);
    assign core_logic_reset = (state_r != ST_RUN);
    assign smbus_master_en  = (state_r == ST_HALT) || (state_r == ST_RUN);

    // ==========================================
    // Strap capture at release only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hold_r      <= `SWPC_HALT_RST;
            switch_mode <= `SWPC_MODE_RST;
        end else if (release_p) begin
            hold_r      <= hold_s;
            switch_mode <= mode_s;
        end
    end

    assign eeprom_init_req = swpc_is_eeprom(switch_mode);
    assign mode_reserved   = swpc_is_reserved(switch_mode);

    // Halt bit: setting at release wins over a clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            halt_bit <= `SWPC_HALT_RST;
        end else if (release_p && hold_s) begin
            halt_bit <= 1'h1;
        end else if (!perst_n_s || halt_bit_clear) begin
            halt_bit <= 1'h0;
        end
    end

    // ==========================================
    // Slot clock bits: strap at release, software afterwards
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            down_slot_clock <= {2{`SWPC_SCLK_RST}};
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (release_p) begin
                    down_slot_clock[i] <= cclk_dn_s;
                end else if (down_sclk_we[i]) begin
                    down_slot_clock[i] <= down_sclk_wdata[i];
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            up_slot_clock <= `SWPC_SCLK_RST;
        end else if (release_p) begin
            up_slot_clock <= cclk_up_s;
        end else if (up_sclk_we) begin
            up_slot_clock <= up_sclk_wdata;
        end
    end

    // ==========================================
    // Auxiliary power and wake
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aux_power_use <= 1'h0;
            wake_event    <= 1'h0;
        end else begin
            aux_power_use <= aux_power_req && aux_off_n_s;
            wake_event    <= !wake_direction_bit && !wake_n_s;
        end
    end

    // Open drain: only ever pulls low
    assign wake_line_n_o  = 1'h0;
    assign wake_line_n_oe = wake_direction_bit && wake_assert_req;

    // ==========================================
    // General purpose pins and their alternates
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            expander_irq0_n <= 1'h1;
            gpio_pin_o      <= 3'h0;
        end else begin
            expander_irq0_n <= gpio_alt_en[`SWPC_GP_IRQ0] ?
                               gpio_s[`SWPC_GP_IRQ0] : 1'h1;
            gpio_pin_o      <= gpio_sw_out;
            if (gpio_alt_en[`SWPC_GP_EVENT]) begin
                gpio_pin_o[`SWPC_GP_EVENT] <= !general_purpose_event;
            end
            if (gpio_alt_en[`SWPC_GP_PORT3]) begin
                gpio_pin_o[`SWPC_GP_PORT3] <= !(port3_reset_req || core_logic_reset);
            end
        end
    end

    always_comb begin
        gpio_pin_oe = gpio_sw_oe;
        if (gpio_alt_en[`SWPC_GP_IRQ0]) begin
            gpio_pin_oe[`SWPC_GP_IRQ0] = 1'h0;
        end
        if (gpio_alt_en[`SWPC_GP_EVENT]) begin
            gpio_pin_oe[`SWPC_GP_EVENT] = 1'h1;
        end
        if (gpio_alt_en[`SWPC_GP_PORT3]) begin
            gpio_pin_oe[`SWPC_GP_PORT3] = 1'h1;
        end
    end

    assign gpio_sw_in = gpio_s;

    // ==========================================
    // Test access port on its own clock
    swpc_tap u_tap (
        .jtag_tck    (jtag_tck),
        .jtag_trst_n (jtag_trst_n),
        .jtag_tms    (jtag_tms),
        .jtag_tdi    (jtag_tdi),
        .jtag_tdo    (jtag_tdo),
        .jtag_tdo_oe (jtag_tdo_oe)
    );

    // ==========================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence seq_release_hold;
        release_p && hold_s;
    endsequence
    sequence seq_done;
        state_r == ST_SEQ && seq_cnt_r == SEQ_LAST && perst_n_s;
    endsequence
    fund_reset_a: assert property (!perst_n_s |=> pcie_fund_reset && core_logic_reset)
        else $error("fundamental reset not entered");
    seq_entry_a: assert property (release_p |=> state_r == ST_SEQ && core_logic_reset)
        else $error("release did not start the reset sequence");
    halt_enter_a: assert property (seq_done and (hold_r && halt_bit)
        |=> state_r == ST_HALT && smbus_master_en && core_logic_reset)
        else $error("hold strap did not halt the device");
    run_enter_a: assert property (seq_done and !hold_r |=> state_r == ST_RUN)
        else $error("sequence end did not reach run");
    halt_stay_a: assert property (state_r == ST_HALT && halt_bit && perst_n_s
        |=> state_r == ST_HALT)
        else $error("halted state left with halt bit set");
    halt_leave_a: assert property (halt_bit && halt_bit_clear && perst_n_s &&
        !release_p && state_r == ST_HALT |=> !halt_bit ##1 state_r == ST_RUN)
        else $error("clearing the halt bit did not release");
    halt_set_a: assert property (seq_release_hold |=> halt_bit)
        else $error("halt bit not set by hold strap");
    mode_hold_a: assert property (!release_p |=> $stable(switch_mode))
        else $error("switch mode changed outside release");
    mode_dec_a: assert property (eeprom_init_req == (switch_mode == `SWPC_MODE_EEPROM)
        && mode_reserved == (switch_mode > `SWPC_MODE_EEPROM))
        else $error("switch mode decode wrong");
    down_load_a: assert property (release_p |=> down_slot_clock == {2{$past(cclk_dn_s)}})
        else $error("downstream slot clock not seeded");
    down_write_a: assert property (!release_p && down_sclk_we[1]
        |=> down_slot_clock[1] == $past(down_sclk_wdata[1]))
        else $error("downstream slot clock write lost");
    up_load_a: assert property (release_p |=> up_slot_clock == $past(cclk_up_s))
        else $error("upstream slot clock not seeded");
    up_write_a: assert property (!release_p && up_sclk_we
        |=> up_slot_clock == $past(up_sclk_wdata))
        else $error("upstream slot clock write lost");
    aux_off_a: assert property (!aux_off_n_s |=> !aux_power_use)
        else $error("auxiliary power used while disabled");
    wake_dir_a: assert property (!wake_direction_bit |-> !wake_line_n_oe)
        else $error("wake pin driven while an input");
    irq_alt_a: assert property (gpio_alt_en[0]
        |=> !$past(gpio_pin_oe[0]) && expander_irq0_n == $past(gpio_s[0]))
        else $error("pin 2 alternate input wrong");
    gpe_alt_a: assert property (gpio_alt_en[1] && general_purpose_event
        |=> !gpio_pin_o[1] && (gpio_pin_oe[1] || !gpio_alt_en[1]))
        else $error("pin 7 event output wrong");
    port3_alt_a: assert property (gpio_alt_en[2] && core_logic_reset
        |=> !gpio_pin_o[2])
        else $error("pin 9 port reset output wrong");

endmodule

`default_nettype wire

// file: hw/swpc_pkg.sv
// Types and decode functions of the system pin control block
`include "swpc_cfg.svh"

package swpc_pkg;

    // ==========================================
    // Reset sequencer
    typedef enum logic [1:0] {
        ST_FUND = 2'h0,
        ST_SEQ  = 2'h1,
        ST_HALT = 2'h2,
        ST_RUN  = 2'h3
    } swpc_state_e;

    typedef logic [2:0] swpc_mode_t;

    // ==========================================
    // Test access port states
    typedef enum logic [3:0] {
        TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SDS = 4'h2, TAP_CDR = 4'h3,
        TAP_SDR = 4'h4, TAP_E1D = 4'h5, TAP_PDR = 4'h6, TAP_E2D = 4'h7,
        TAP_UDR = 4'h8, TAP_SIS = 4'h9, TAP_CIR = 4'hA, TAP_SIR = 4'hB,
        TAP_E1I = 4'hC, TAP_PIR = 4'hD, TAP_E2I = 4'hE, TAP_UIR = 4'hF
    } swpc_tap_e;

    function automatic logic swpc_is_eeprom(input swpc_mode_t m);
        return m == `SWPC_MODE_EEPROM;
    endfunction

    function automatic logic swpc_is_reserved(input swpc_mode_t m);
        return m > `SWPC_MODE_EEPROM;
    endfunction

endpackage

// file: hw/swpc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
`include "swpc_cfg.svh"

module swpc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= {W{`SWPC_SYNC_RST}};
            q      <= {W{`SWPC_SYNC_RST}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

`default_nettype wire

// file: hw/swpc_tap.sv
// Test access port: clocked by the test clock only
`timescale 1ns/1ps
`default_nettype none
`include "swpc_cfg.svh"

module swpc_tap
    import swpc_pkg::*;
#(
    // Arbitrary neutral identity value
    parameter logic [31:0] ID_VALUE = 32'h0000_0001
) (
    // Test pins
    input  wire logic jtag_tck,
    input  wire logic jtag_trst_n,
    input  wire logic jtag_tms,
    input  wire logic jtag_tdi,
    output logic      jtag_tdo,
    output logic      jtag_tdo_oe
);

    swpc_tap_e              st_r;
    swpc_tap_e              st_nxt;
    logic [`SWPC_IR_W-1:0]  ir_r;
    logic [`SWPC_IR_W-1:0]  ir_sh_r;
    logic [31:0]            dr_sh_r;

    // ==========================================
    // State walk under the mode select
    always_comb begin
        case (st_r)
            TAP_TLR: st_nxt = jtag_tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: st_nxt = jtag_tms ? TAP_SDS : TAP_RTI;
            TAP_SDS: st_nxt = jtag_tms ? TAP_SIS : TAP_CDR;
            TAP_CDR: st_nxt = jtag_tms ? TAP_E1D : TAP_SDR;
            TAP_SDR: st_nxt = jtag_tms ? TAP_E1D : TAP_SDR;
            TAP_E1D: st_nxt = jtag_tms ? TAP_UDR : TAP_PDR;
            TAP_PDR: st_nxt = jtag_tms ? TAP_E2D : TAP_PDR;
            TAP_E2D: st_nxt = jtag_tms ? TAP_UDR : TAP_SDR;
            TAP_UDR: st_nxt = jtag_tms ? TAP_SDS : TAP_RTI;
            TAP_SIS: st_nxt = jtag_tms ? TAP_TLR : TAP_CIR;
            TAP_CIR: st_nxt = jtag_tms ? TAP_E1I : TAP_SIR;
            TAP_SIR: st_nxt = jtag_tms ? TAP_E1I : TAP_SIR;
            TAP_E1I: st_nxt = jtag_tms ? TAP_UIR : TAP_PIR;
            TAP_PIR: st_nxt = jtag_tms ? TAP_E2I : TAP_PIR;
            TAP_E2I: st_nxt = jtag_tms ? TAP_UIR : TAP_SIR;
            TAP_UIR: st_nxt = jtag_tms ? TAP_SDS : TAP_RTI;
            default: st_nxt = TAP_TLR;
        endcase
    end

    always_ff @(posedge jtag_tck or negedge jtag_trst_n) begin
        if (!jtag_trst_n) begin
            st_r <= TAP_TLR;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // Instruction and data shifting
    always_ff @(posedge jtag_tck or negedge jtag_trst_n) begin
        if (!jtag_trst_n) begin
            ir_r    <= `SWPC_IR_IDCODE;
            ir_sh_r <= `SWPC_IR_CAPTURE;
            dr_sh_r <= 32'h0000_0000;
        end else begin
            case (st_r)
                TAP_TLR: ir_r <= `SWPC_IR_IDCODE;
                TAP_CIR: ir_sh_r <= `SWPC_IR_CAPTURE;
                TAP_SIR: ir_sh_r <= {jtag_tdi, ir_sh_r[`SWPC_IR_W-1:1]};
                TAP_UIR: ir_r <= ir_sh_r;
                TAP_CDR: dr_sh_r <= (ir_r == `SWPC_IR_IDCODE) ? ID_VALUE : 32'h0000_0000;
                TAP_SDR: begin
                    if (ir_r == `SWPC_IR_IDCODE) begin
                        dr_sh_r <= {jtag_tdi, dr_sh_r[31:1]};
                    end else begin
                        dr_sh_r <= {31'h0000_0000, jtag_tdi};
                    end
                end
                default: ;
            endcase
        end
    end

    // Output changes on the falling edge; driven only while shifting
    always_ff @(negedge jtag_tck or negedge jtag_trst_n) begin
        if (!jtag_trst_n) begin
            jtag_tdo    <= 1'h0;
            jtag_tdo_oe <= 1'h0;
        end else begin
            jtag_tdo    <= (st_r == TAP_SIR) ? ir_sh_r[0] : dr_sh_r[0];
            jtag_tdo_oe <= (st_r == TAP_SIR) || (st_r == TAP_SDR);
        end
    end

    // ==========================================
    // Checks
    tdo_hiz_a: assert property (@(posedge jtag_tck) disable iff (!jtag_trst_n)
        (st_r != TAP_SIR) && (st_r != TAP_SDR) |-> !jtag_tdo_oe)
        else $error("test data output driven outside shifting");

    tms_reset_a: assert property (@(posedge jtag_tck) disable iff (!jtag_trst_n)
        jtag_tms [*5] |=> st_r == TAP_TLR)
        else $error("five high mode selects did not reach logic reset");

    trst_async_a: assert property (@(posedge jtag_tck)
        !jtag_trst_n |-> st_r == TAP_TLR && !jtag_tdo_oe)
        else $error("test reset did not force logic reset");

endmodule

`default_nettype wire

// file: test/swpc_board.sv
// Board model: reset, strap and test pins seen by the pin control block
`timescale 1ns/1ps
`default_nettype none
module swpc_board (
    // Bench control
    input  wire logic       clk,
    input  wire logic       perst_req,
    input  wire logic [5:0] straps,
    input  wire logic       tap_on,
    // Pins
    output logic            fundamental_reset_n,
    output logic            reset_hold_strap,
    output logic [2:0]      switch_mode_strap,
    output logic            common_clock_down_strap,
    output logic            common_clock_up_strap,
    output logic            jtag_trst_n,
    output logic            jtag_tck
);
    always_ff @(posedge clk) begin
        fundamental_reset_n <= !perst_req;
        {reset_hold_strap, switch_mode_strap, common_clock_down_strap,
            common_clock_up_strap} <= straps;
    end
    // Functional operation keeps test logic in reset; test clock idles low
    assign jtag_trst_n = tap_on;
    always_ff @(negedge clk) begin
        jtag_tck <= tap_on && !jtag_tck;
    end
endmodule
`default_nettype wire

// file: test/test_switch_system_pin_control.sv
// Bench of the system pin control block
`timescale 1ns/1ps
`default_nettype none
module test_switch_system_pin_control;
    logic core_clk, rst, perst_req, halt_bit_clear, up_sclk_we, up_sclk_wdata, aux_power_off_n;
    logic aux_power_req, wake_direction_bit, wake_assert_req, wake_drv_n, general_purpose_event;
    logic port3_reset_req, pcie_fund_reset, core_logic_reset, smbus_master_en, eeprom_init_req;
    logic mode_reserved, halt_bit, up_slot_clock, aux_power_use, wake_line_n_o, wake_line_n_oe;
    logic wake_event, expander_irq0_n, jtag_tdo, jtag_tdo_oe, tap_on, jtag_tms;
    logic [3:0] tdo_sh;
    logic [5:0] straps;
    logic [1:0] down_sclk_we, down_sclk_wdata, down_slot_clock;
    logic [2:0] gpio_alt_en, gpio_sw_out, gpio_sw_oe, gpio_drv, gpio_pin_o, gpio_pin_oe;
    logic [2:0] gpio_sw_in, switch_mode;
    wire logic fundamental_reset_n, reset_hold_strap, common_clock_down_strap;
    wire logic common_clock_up_strap, jtag_trst_n, jtag_tck, wake_line_n_i;
    wire logic [2:0] switch_mode_strap, gpio_pin_i;
    int bad_count, checked;
    // Wire levels: open-drain wake with pull-up, bench drive gpio_drv on idle pins
    assign wake_line_n_i = (wake_line_n_oe ? wake_line_n_o : 1'h1) & wake_drv_n;
    assign gpio_pin_i = (gpio_pin_oe & gpio_pin_o) | (~gpio_pin_oe & gpio_drv);
    swpc_board i_board (.clk(core_clk), .perst_req, .straps, .tap_on, .fundamental_reset_n,
        .reset_hold_strap, .switch_mode_strap, .common_clock_down_strap,
        .common_clock_up_strap, .jtag_trst_n, .jtag_tck);
    swpc_pin_ctrl i_dut (.core_clk, .rst, .fundamental_reset_n, .reset_hold_strap,
        .switch_mode_strap, .common_clock_down_strap, .common_clock_up_strap, .aux_power_off_n,
        .pcie_fund_reset, .core_logic_reset, .smbus_master_en, .switch_mode, .eeprom_init_req,
        .mode_reserved, .halt_bit_clear, .halt_bit, .down_sclk_we, .down_sclk_wdata, .up_sclk_we,
        .up_sclk_wdata, .down_slot_clock, .up_slot_clock, .aux_power_req, .aux_power_use,
        .wake_direction_bit, .wake_assert_req, .wake_line_n_i, .wake_line_n_o, .wake_line_n_oe,
        .wake_event, .gpio_alt_en, .gpio_sw_out, .gpio_sw_oe, .gpio_pin_i, .gpio_pin_o,
        .gpio_pin_oe, .gpio_sw_in, .general_purpose_event, .port3_reset_req, .expander_irq0_n,
        .jtag_tck, .jtag_trst_n, .jtag_tms, .jtag_tdi(1'h0), .jtag_tdo, .jtag_tdo_oe);
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task chk(input logic [3:0] g, input logic [3:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %0t got %h want %h", $time, g, e);
        end
    endtask
    task tap(input logic m, input int n);
        repeat (n) begin
            @(posedge jtag_tck);
            tdo_sh = {jtag_tdo_oe & jtag_tdo, tdo_sh[3:1]};
            jtag_tms <= m;
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        core_clk = 0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #20000 bad_count++;
        finish_test;
    end
    initial begin
        {rst, perst_req, straps, halt_bit_clear, up_sclk_we, up_sclk_wdata} = {2'h3, 6'h26, 3'h0};
        {aux_power_off_n, aux_power_req, wake_direction_bit, wake_assert_req, wake_drv_n} = 5'h19;
        {down_sclk_we, down_sclk_wdata, gpio_alt_en, gpio_sw_out, gpio_sw_oe} = 13'h0;
        {gpio_drv, general_purpose_event, port3_reset_req, tap_on, jtag_tms} = 7'h70;
        cyc(4); rst <= 0;
        cyc(3); perst_req <= 0;
        @(negedge core_clk);
        chk({eeprom_init_req, mode_reserved, pcie_fund_reset, smbus_master_en}, 4'h2);
        cyc(6); straps <= 6'h00;
        cyc(260); @(negedge core_clk);
        chk(halt_bit, 1);
        chk({eeprom_init_req, mode_reserved, switch_mode[1:0]}, 4'h9);
        chk({down_slot_clock, up_slot_clock}, 4'h6);
        chk({smbus_master_en, core_logic_reset, pcie_fund_reset}, 4'h6);
        cyc(1); halt_bit_clear <= 1;
        cyc(1); halt_bit_clear <= 0;
        cyc(2); @(negedge core_clk);
        chk({halt_bit, core_logic_reset}, 4'h0);
        $display("test halt strap done");
        cyc(1); {down_sclk_we, down_sclk_wdata, up_sclk_we, up_sclk_wdata} <= 6'h3B;
        cyc(1); {down_sclk_we, up_sclk_we} <= 3'h0;
        @(negedge core_clk);
        chk({down_slot_clock, up_slot_clock}, 4'h5);
        cyc(1); {gpio_alt_en, general_purpose_event, port3_reset_req, gpio_drv} <= 8'hFE;
        aux_power_off_n <= 0;
        cyc(4); @(negedge core_clk);
        chk({gpio_pin_oe, gpio_pin_o[2]}, 4'hC);
        chk({expander_irq0_n, aux_power_use, gpio_pin_o[1]}, 4'h0);
        cyc(1); aux_power_off_n <= 1;
        {wake_direction_bit, wake_assert_req} <= 2'h3;
        cyc(4); @(negedge core_clk);
        chk({aux_power_use, wake_line_n_oe, wake_line_n_o, jtag_tdo_oe}, 4'hC);
        cyc(1); {wake_direction_bit, wake_drv_n} <= 2'h0;
        cyc(4); @(negedge core_clk);
        chk({wake_line_n_oe, wake_event}, 4'h1);
        $display("test pins done");
        cyc(1); perst_req <= 1;
        straps <= 6'h08;
        cyc(5); @(negedge core_clk);
        chk({pcie_fund_reset, core_logic_reset, halt_bit}, 4'h6);
        cyc(1); perst_req <= 0;
        cyc(265); @(negedge core_clk);
        chk({mode_reserved, core_logic_reset, down_slot_clock}, 4'h8);
        chk(up_slot_clock, 0);
        $display("test second reset done");
        cyc(1); tap_on <= 1;
        tap(1, 1); tap(0, 3);
        tap(0, 3); tap(1, 1);
        chk(tdo_sh, 4'h1);
        tap(1, 6);
        chk(jtag_tdo_oe, 0);
        cyc(1); tap_on <= 0;
        $display("test tap done");
        finish_test;
    end
endmodule
`default_nettype wire
